// file: verif/rpw_assertions.sv
/* rpw_assertions: port checks on rpw_top.
   Assumes bind from the bench top, zero-wait slave. */
`timescale 1ns/1ps
`default_nettype none
module rpw_assertions
  import rpw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 2 // core cycles per tick
)(
  // clock, reset, bus
  input wire logic          clock,
  input wire logic          resetn,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [31:0]   hrdata,
  // system side
  input wire logic          sleep_mode,
  input wire logic          supply_above_level,
  input wire logic          system_reset,
  input wire logic          cold_reset,
  input wire logic          standby_reset_status_pin,
  input wire rpw_cpu_init_s cpu_init,
  input wire logic          prescaler_irq,
  input wire logic          rising_edge_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // data phase tracking
  // ****************************************************************
  logic       rd_q; // read in data phase
  logic       wr_q; // write in data phase
  logic [7:0] ra_q; // its address
  // remember each taken transfer to the register page (haddr[31:8] zero)
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ra_q <= 8'h00;
    end
    else
    begin
      rd_q <= hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000;
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h00_0000;
      ra_q <= haddr[7:0];
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_bus; hreadyout && !hresp; endproperty
  property p_init; system_reset |-> cpu_init == {PC_INIT, IR_JUMP0, 1'b0, SP_INIT}; endproperty
  property p_cold; cold_reset |-> system_reset; endproperty
  property p_pin; system_reset && $past(system_reset) |-> standby_reset_status_pin; endproperty
  property p_pulse; prescaler_irq |=> !prescaler_irq [*8]; endproperty
  property p_sleep; sleep_mode [*3] |-> !prescaler_irq; endproperty
  property p_edge;
    wr_q && ra_q == A_OPTION && !system_reset |-> ##2 rising_edge_active == $past(hwdata[3], 2);
  endproperty
  property p_flags; rd_q && ra_q == A_PA_IRQ |-> hrdata[31:4] == 28'h000_0000; endproperty
  property p_wdclr; rd_q && ra_q == A_WDOG |-> !hrdata[3]; endproperty
  property p_supply; $fell(cold_reset) |-> $past(supply_above_level, 2); endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready/okay");
  a_init: assert property (p_init) else $error("cpu start state wrong");
  a_cold: assert property (p_cold) else $error("cold hold without reset");
  a_pin: assert property (p_pin) else $error("status pin low in reset");
  a_pulse: assert property (p_pulse) else $error("tick irq too close");
  a_sleep: assert property (p_sleep) else $error("tick irq in sleep");
  a_edge: assert property (p_edge) else $error("edge select not taken");
  a_flags: assert property (p_flags) else $error("flag upper bits set");
  a_wdclr: assert property (p_wdclr) else $error("restart bit reads one");
  a_supply: assert property (p_supply) else $error("cold release, supply low");
  c_irq: cover property (prescaler_irq);
  c_rel: cover property ($fell(system_reset));
  c_edge: cover property ($rose(rising_edge_active));
endmodule
`default_nettype wire

// file: verif/rpw_bench.sv
/* rpw_bench: self-checking bench for rpw_top.
   Assumes TICK_CYCLES 2, so start-up is 65536 core cycles. */
`timescale 1ns/1ps
`default_nettype none
module rpw_bench
  import rpw_pkg::*;
;
  logic clock = 0, resetn = 0, hsel = 0, hwrite = 0, sleep_mode = 0, sup_want = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [3:0] pa_want = 0, pc_want = 0;
  wire hreadyout, hresp, system_reset, cold_reset, pin, sup, summary, pirq, rea, bt1, bt2, bt3;
  wire [31:0] hrdata;
  wire [3:0] pa, pc, pcc;
  wire rpw_cpu_init_s cpu_init;
  wire hready = hreadyout; // single slave
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic [31:0] seed = 6, r;
  always #2 clock = ~clock;
  rpw_top #(.TICK_CYCLES(2), .POWER_CHECK(1'b1)) rpw_top_inst (.clock(clock), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_mode(sleep_mode), .supply_above_level(sup), .system_reset(system_reset),
    .cold_reset(cold_reset), .standby_reset_status_pin(pin), .cpu_init(cpu_init),
    .port_a_in(pa), .port_c_in(pc), .port_c_conditioned(pcc), .branch_test_one(bt1),
    .branch_test_two(bt2), .branch_test_three(bt3), .port_a_summary_request(summary),
    .prescaler_irq(pirq), .rising_edge_active(rea));
  rpw_partner rpw_partner_inst (.clock(clock), .pa_want(pa_want), .pc_want(pc_want),
    .sup_want(sup_want), .port_a_in(pa), .port_c_in(pc), .supply_above_level(sup));
  // repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one ahb-lite single word transfer, waits on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 96000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    int n, tg;
    logic [3:0] m, v, e;
    logic p;
    repeat (5) @(posedge clock);
    chk({1'b0, cpu_init}, {1'b0, PC_INIT, IR_JUMP0, 1'b0, SP_INIT});
    chk({system_reset, cold_reset, pin}, 3'b111);
    resetn <= 1'b1;
    repeat (66000) @(posedge clock);
    chk(system_reset, 1'b1);
    sup_want <= 1'b1;
    n = 0;
    while (system_reset !== 1'b0 && n < 8300)
    begin
      @(posedge clock);
      n++;
    end
    chk(system_reset, 1'b0);
    $display("test start-up done");
    rdc(A_OPTION, 0);
    rdc(A_PA_MSK, 0);
    rdc(A_PA_IRQ, 0);
    rdc(A_PRESCALER_CONTROL, 0);
    rdc(8'h1C, 0);
    repeat (4)
    begin
      v = xs();
      bus(1'b1, A_OPTION, v);
      rdc(A_OPTION, v);
      bus(1'b1, A_PA_MSK, 4'(~v));
      rdc(A_PA_MSK, 4'(~v));
      bus(1'b1, A_PRESCALER_CONTROL, v);
      rdc(A_PRESCALER_CONTROL, v & 4'hB);
    end
    bus(1'b1, A_WDOG, 8);
    $display("test registers done");
    for (int i = 0; i < 2; i++)
    begin
      e = i[3:0];
      bus(1'b1, A_OPTION, i ? 4'hB : 4'h3);
      repeat (2) @(posedge clock);
      chk(rea, e[0]);
      m = xs();
      m[0] = 1'b1;
      bus(1'b1, A_PA_MSK, m);
      pa_want <= i ? 4'h0 : 4'hF;
      pc_want <= xs();
      repeat (6) @(posedge clock);
      bus(1'b0, A_PA_IRQ, 0);
      v = xs();
      pa_want <= v;
      repeat (6) @(posedge clock);
      m = m & (i ? v : ~v);
      chk(summary, |m);
      rdc(A_PA_IRQ, m);
      rdc(A_PA_IRQ, 0);
      repeat (2) @(posedge clock);
      chk(summary, 1'b0);
    end
    $display("test edges done");
    bus(1'b1, A_OPTION, 1);
    bus(1'b1, A_PA_AUX, 0);
    v = xs();
    pa_want <= v;
    pc_want <= v;
    repeat (300) @(posedge clock);
    chk({bt3, bt2, bt1}, v[2:0]);
    chk(pcc, v);
    pa_want <= ~v;
    pc_want <= ~v;
    repeat (16) @(posedge clock);
    chk({bt3, bt2, bt1}, v[2:0]);
    chk(pcc, v);
    repeat (300) @(posedge clock);
    chk({bt3, bt2, bt1}, 3'(~v[2:0]));
    chk(pcc, 4'(~v));
    $display("test debounce done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, A_PRESCALER_CONTROL, i);
      repeat (2) @(posedge clock);
      n = 0;
      repeat (i == 2 ? 8192 : 2048)
      begin
        @(posedge clock);
        n += (pirq === 1'b1);
      end
      chk(i == 1 ? (n > 1) : n, i == 3 || i == 2);
    end
    $display("test ticks done");
    bus(1'b1, A_PA_AUX, 1);
    for (int s = 0; s < 2; s++)
    begin
      sleep_mode <= s[0];
      repeat (4) @(posedge clock);
      tg = 0;
      p = pin;
      repeat (32)
      begin
        @(posedge clock);
        tg += (pin !== p);
        p = pin;
      end
      chk(tg >= 8, !s);
    end
    sleep_mode <= 1'b0;
    bus(1'b1, A_PA_AUX, 0);
    repeat (4) @(posedge clock);
    chk(pin, 1'b0);
    $display("test clock out done");
    finish_test();
  end
endmodule
bind rpw_top rpw_assertions #(.TICK_CYCLES(TICK_CYCLES)) rpw_assertions_inst (.clock(clock),
  .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sleep_mode(sleep_mode), .supply_above_level(supply_above_level),
  .system_reset(system_reset), .cold_reset(cold_reset),
  .standby_reset_status_pin(standby_reset_status_pin), .cpu_init(cpu_init),
  .prescaler_irq(prescaler_irq), .rising_edge_active(rising_edge_active));
`default_nettype wire

// file: verif/rpw_partner.sv
/* rpw_partner: port pins and supply comparator seen by the block.
   Assumes the bench sets the wanted levels; pins change on clock. */
`timescale 1ns/1ps
`default_nettype none
module rpw_partner (
  // wanted levels from the bench
  input wire logic      clock,
  input wire logic [3:0] pa_want,
  input wire logic [3:0] pc_want,
  input wire logic      sup_want,
  // pins toward the block
  output var logic [3:0] port_a_in = 4'h0,
  output var logic [3:0] port_c_in = 4'h0,
  output var logic      supply_above_level = 1'b0
);
  // pins move one edge after the request, like a synchronised pad
  always_ff @(posedge clock)
  begin
    port_a_in <= pa_want;
    port_c_in <= pc_want;
    supply_above_level <= sup_want;
  end
endmodule
`default_nettype wire

// file: verilog/rpw_pkg.sv
/*
  rpw_pkg: shared constants and types for the reset, prescaler, watchdog
  and port A support block.
  Assumes a 250 MHz core clock from which the 32.768 kHz system tick is made.
*/
`default_nettype none

package rpw_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ       = 250_000_000; // core clock rate
  localparam int unsigned SYS_CLK_HZ     = 32_768;      // system clock rate
  localparam int unsigned SYS_TICK_CYC   = CLOCK_HZ / SYS_CLK_HZ; // cycles per tick
  localparam int unsigned COLD_TICKS     = 32_768;      // oscillator start-up ticks
  localparam int unsigned FIRST_CHK_TICK = 16_384;      // first supply comparison
  localparam int unsigned PRESCALER_CONTROL_STAGES   = 15;          // divider chain length
  localparam int unsigned WD_TIMEOUT_S   = 3;           // watchdog seconds

  // prescaler stage indices (stage n toggles at 32768 / 2^(n+1) Hz)
  localparam int unsigned ST_1HZ    = 14;
  localparam int unsigned ST_8HZ    = 11;
  localparam int unsigned ST_32HZ   = 9;
  localparam int unsigned ST_128HZ  = 7;
  localparam int unsigned ST_1024HZ = 4;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] A_PRESCALER_CONTROL  = 8'h00; // prescaler_control
  localparam logic [7:0] A_WDOG   = 8'h04; // watchdog_control
  localparam logic [7:0] A_OPTION = 8'h08; // option_settings
  localparam logic [7:0] A_PA_IN  = 8'h0C; // port A input status
  localparam logic [7:0] A_PA_IRQ = 8'h10; // port_a_request_flags
  localparam logic [7:0] A_PA_MSK = 8'h14; // port_a_mask_register
  localparam logic [7:0] A_PA_AUX = 8'h18; // port_a_aux_control

  // field positions
  localparam int unsigned B_TIM_MASK   = 3; // timer_irq_mask
  localparam int unsigned B_PRESCALER_CONTROL_CLR  = 2; // divider_chain_clear
  localparam int unsigned B_WD_CLEAR   = 3; // watchdog_clear
  localparam int unsigned B_SLEEP_MASK = 2;
  localparam int unsigned B_RISE_SEL   = 3; // rising_edge_select
  localparam int unsigned B_PC_BYPASS  = 2; // port_c_debounce_bypass
  localparam int unsigned B_PA_BYPASS  = 1; // port_a_debounce_bypass
  localparam int unsigned B_WD_DISABLE = 0; // watchdog_disable
  localparam int unsigned B_FOUT       = 0; // clock out on status pin
  localparam int unsigned B_DEB_SLOW   = 1; // debounce on 128 Hz

  // reset values
  localparam logic [3:0]  RST_NIBBLE = 4'h0;
  localparam logic [11:0] PC_INIT    = 12'h000;
  localparam logic [15:0] IR_JUMP0   = 16'h0000; // jump-to-zero opcode, arbitrary
  localparam logic [1:0]  SP_INIT    = 2'h0;

  // prescaler interrupt select codes
  typedef enum logic [1:0] {PSEL_NONE, PSEL_1HZ, PSEL_8HZ, PSEL_32HZ} rpw_psel_e;

  // cpu state loaded on any reset
  typedef struct packed {
    logic [11:0] first_program_counter;
    logic [15:0] instruction_word;
    logic        halt;
    logic [1:0]  stack_level_pointer;
  } rpw_cpu_init_s;

endpackage

`default_nettype wire

// file: verilog/rpw_top.sv
/*
  rpw_top: reset sequencing with power check, 15-stage prescaler, watchdog,
  option register and port A input conditioning with masked edge requests.
  Assumes an AHB-Lite master with single word transfers, inputs synchronous
  to clock, and a supply comparator result from the level detector.
*/
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rpw_top
  import rpw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SYS_TICK_CYC, // core cycles per system tick
  parameter bit          POWER_CHECK = 1'b1           // power check build option
)(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // ahb-lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // system control
  input  wire logic          sleep_mode,
  input  wire logic          supply_above_level,
  output logic               system_reset,
  output logic               cold_reset,
  output logic               standby_reset_status_pin,
  output rpw_cpu_init_s      cpu_init,
  // ports
  input  wire logic [3:0]    port_a_in,
  input  wire logic [3:0]    port_c_in,
  output logic [3:0]         port_c_conditioned,
  output logic               branch_test_one,
  output logic               branch_test_two,
  output logic               branch_test_three,
  output logic               port_a_summary_request,
  output logic               prescaler_irq,
  output logic               rising_edge_active
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // stage n rises on this tick when all lower stages are ones and n is zero
  function automatic logic stage_rise(input logic [14:0] cnt, input int unsigned n);
    logic [14:0] low;
    low = (15'h0001 << n) - 15'h0001;
    return ((cnt & low) == low) && !cnt[n];
  endfunction

  // ****************************************************************
  // system tick from the core clock
  // ****************************************************************
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0] tdiv_q;      // core cycle counter
  logic          tick;        // one system clock period elapsed
  logic          sysclk_lvl;  // square wave of the system clock

  assign tick       = (tdiv_q == TW'(TICK_CYCLES - 1)) && !sleep_mode;
  assign sysclk_lvl = (tdiv_q < TW'(TICK_CYCLES / 2));

  // divider held at zero while sleeping so no derived clock advances
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      tdiv_q <= '0;
    else if (sleep_mode)
      tdiv_q <= '0;
    else if (tick)
      tdiv_q <= '0;
    else
      tdiv_q <= tdiv_q + TW'(1);
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic [3:0]  prescaler_control_q;     // prescaler_control
  logic        wd_sleep_q;  // sleep mask bit
  logic [3:0]  option_q;    // option_settings
  logic [3:0]  mask_q;      // port_a_mask_register
  logic [1:0]  aux_q;       // port_a_aux_control
  logic [3:0]  flags_q;     // port_a_request_flags
  logic [1:0]  wd_cnt_q;    // watchdog stages
  logic [3:0]  pa_cond;     // port A input to edge logic
  logic        wr_pend_q;   // data phase of a write
  logic [7:0]  wr_addr_q;   // write address held for data phase
  logic        addr_ok;     // valid address phase
  logic        rd_now;      // read taken this cycle
  logic        wr_data;     // write data present this cycle
  logic        flag_rd;     // read of the request flags
  logic        soft_rst;    // system reset to registers
  logic [31:0] rd_val;      // read mux

  assign addr_ok = hsel && hready && htrans[1];
  assign rd_now  = addr_ok && !hwrite;
  assign wr_data = wr_pend_q;
  assign flag_rd = rd_now && (haddr[7:0] == A_PA_IRQ) && (haddr[31:8] == 24'h0000_00);

  // read mux built in the address phase and registered for the data phase
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] != 24'h0000_00)
      rd_val = 32'h0000_0000;                              // unmapped reads zero
    else if (haddr[7:0] == A_PRESCALER_CONTROL)
      rd_val = {28'h000_0000, prescaler_control_q};
    else if (haddr[7:0] == A_WDOG)
      rd_val = {28'h000_0000, 1'b0, wd_sleep_q, wd_cnt_q};
    else if (haddr[7:0] == A_OPTION)
      rd_val = {28'h000_0000, option_q};
    else if (haddr[7:0] == A_PA_IN)
      rd_val = {28'h000_0000, port_a_in};
    else if (haddr[7:0] == A_PA_IRQ)
      rd_val = {28'h000_0000, flags_q};
    else if (haddr[7:0] == A_PA_MSK)
      rd_val = {28'h000_0000, mask_q};
    else if (haddr[7:0] == A_PA_AUX)
      rd_val = {30'h0000_0000, aux_q};
    else
      rd_val = 32'h0000_0000;
  end

  // zero wait state, always OKAY
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_now)
        hrdata <= rd_val;
      if (hready)
        wr_pend_q <= addr_ok && hwrite && (haddr[31:8] == 24'h0000_00);
      if (addr_ok)
        wr_addr_q <= haddr[7:0];
    end
  end

  // control registers except wd_sleep_q, cleared by any system reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prescaler_control_q    <= RST_NIBBLE;
      wd_sleep_q <= 1'b0;
      option_q   <= RST_NIBBLE;
      mask_q     <= RST_NIBBLE;
      aux_q      <= 2'b00;
    end
    else if (soft_rst)
    begin
      prescaler_control_q    <= RST_NIBBLE;
      option_q   <= RST_NIBBLE;
      mask_q     <= RST_NIBBLE;
      aux_q      <= 2'b00;
    end
    else if (wr_data)
    begin
      if (wr_addr_q == A_PRESCALER_CONTROL)
        prescaler_control_q <= {hwdata[3], 1'b0, hwdata[1:0]};         // clear bit self-clears
      else if (wr_addr_q == A_WDOG)
        wd_sleep_q <= hwdata[B_SLEEP_MASK];
      else if (wr_addr_q == A_OPTION)
        option_q <= hwdata[3:0];
      else if (wr_addr_q == A_PA_MSK)
        mask_q <= hwdata[3:0];
      else if (wr_addr_q == A_PA_AUX)
        aux_q <= hwdata[1:0];
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [14:0] psc_q;       // fifteen stage divider chain
  logic        psc_clr;     // software clears the chain
  logic        r1, r8, r32, r128, r1024;
  logic        psel_hit;

  assign psc_clr = wr_data && (wr_addr_q == A_PRESCALER_CONTROL) && hwdata[B_PRESCALER_CONTROL_CLR];
  assign r1      = tick && stage_rise(psc_q, ST_1HZ);
  assign r8      = tick && stage_rise(psc_q, ST_8HZ);
  assign r32     = tick && stage_rise(psc_q, ST_32HZ);
  assign r128    = tick && stage_rise(psc_q, ST_128HZ);
  assign r1024   = tick && stage_rise(psc_q, ST_1024HZ);

  // divider advances once per system tick
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      psc_q <= 15'h0000;
    else if (psc_clr)
      psc_q <= 15'h0000;
    else if (tick)
      psc_q <= psc_q + 15'h0001;
  end

  // interrupt source selection
  always_comb
  begin
    case (rpw_psel_e'(prescaler_control_q[1:0]))
      PSEL_1HZ:  psel_hit = r1;
      PSEL_8HZ:  psel_hit = r8;
      PSEL_32HZ: psel_hit = r32;
      default:   psel_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      prescaler_irq <= 1'b0;
    else
      prescaler_irq <= psel_hit && !soft_rst;
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  logic wd_clr;    // software restart
  logic wd_fire;   // third 1 Hz edge without restart

  assign wd_clr  = wr_data && (wr_addr_q == A_WDOG) && hwdata[B_WD_CLEAR];
  assign wd_fire = r1 && (wd_cnt_q == 2'(WD_TIMEOUT_S - 1)) && !wd_clr;

  // counts 1 Hz edges; standby does not stop it, sleep does via tick
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      wd_cnt_q <= 2'b00;
    else if (wd_clr || soft_rst)
      wd_cnt_q <= 2'b00;
    else if (wd_fire)
      wd_cnt_q <= 2'b00;
    else if (r1)
      wd_cnt_q <= wd_cnt_q + 2'b01;
  end

  // ****************************************************************
  // cold reset with power check
  // ****************************************************************
  logic [15:0] cold_cnt_q;  // system ticks since power-on
  logic        cold_done_q; // start-up count finished
  logic        supply_ok_q; // a comparison has passed
  logic        chk_now;     // comparison instant
  logic        cold_hold;

  assign chk_now   = POWER_CHECK && !supply_ok_q &&
                     ((tick && cold_cnt_q == 16'(FIRST_CHK_TICK - 1)) ||
                      (r8 && cold_cnt_q >= 16'(FIRST_CHK_TICK)));
  assign cold_hold = !cold_done_q || (POWER_CHECK && !supply_ok_q);

  // start-up counter and supply comparison
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cold_cnt_q  <= 16'h0000;
      cold_done_q <= 1'b0;
      supply_ok_q <= 1'b0;
    end
    else
    begin
      if (tick && !cold_done_q)
      begin
        cold_cnt_q  <= cold_cnt_q + 16'h0001;
        cold_done_q <= (cold_cnt_q == 16'(COLD_TICKS - 1));
      end
      if (chk_now && supply_above_level)
        supply_ok_q <= 1'b1;
    end
  end

  // system reset: cold hold or a watchdog time-out
  assign soft_rst = system_reset;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cold_reset   <= 1'b1;
      system_reset <= 1'b1;
    end
    else
    begin
      cold_reset   <= cold_hold;
      system_reset <= cold_hold || (wd_fire && !option_q[B_WD_DISABLE]);
    end
  end

  // cpu state during and after reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cpu_init <= '{PC_INIT, IR_JUMP0, 1'b0, SP_INIT};
    else if (system_reset)
      cpu_init <= '{PC_INIT, IR_JUMP0, 1'b0, SP_INIT};
  end

  // status pin: high in reset, else optional system clock
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      standby_reset_status_pin <= 1'b1;
    else
      standby_reset_status_pin <= system_reset ||
                                  (aux_q[B_FOUT] && sysclk_lvl && !sleep_mode);
  end

  // ****************************************************************
  // debouncers
  // ****************************************************************
  logic       deb_edge;   // selected debounce clock rising
  logic [3:0] pa_smp_q;   // last port A sample
  logic [3:0] pa_deb_q;   // accepted port A value
  logic [3:0] pc_smp_q;
  logic [3:0] pc_deb_q;

  assign deb_edge = aux_q[B_DEB_SLOW] ? r128 : r1024;

  // accept a value seen on two successive debounce edges
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pa_smp_q <= 4'h0;
      pa_deb_q <= 4'h0;
      pc_smp_q <= 4'h0;
      pc_deb_q <= 4'h0;
    end
    else if (deb_edge)
    begin
      pa_smp_q <= port_a_in;
      pc_smp_q <= port_c_in;
      pa_deb_q <= (pa_smp_q & port_a_in) | (pa_deb_q & (pa_smp_q | port_a_in));
      pc_deb_q <= (pc_smp_q & port_c_in) | (pc_deb_q & (pc_smp_q | port_c_in));
    end
  end

  assign pa_cond = option_q[B_PA_BYPASS] ? port_a_in : pa_deb_q;

  // conditioned outputs
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      port_c_conditioned <= 4'h0;
      branch_test_one    <= 1'b0;
      branch_test_two    <= 1'b0;
      branch_test_three  <= 1'b0;
      rising_edge_active <= 1'b0;
    end
    else
    begin
      port_c_conditioned <= option_q[B_PC_BYPASS] ? port_c_in : pc_deb_q;
      branch_test_one    <= pa_deb_q[0];
      branch_test_two    <= pa_deb_q[1];
      branch_test_three  <= pa_deb_q[2];
      rising_edge_active <= option_q[B_RISE_SEL];
    end
  end

  // ****************************************************************
  // port A edge requests
  // ****************************************************************
  logic [3:0] pa_prev_q;  // previous conditioned value
  logic [3:0] act_edge;   // active edges this cycle
  logic [3:0] flags_d;

  assign act_edge = option_q[B_RISE_SEL] ? (pa_cond & ~pa_prev_q)
                                         : (~pa_cond & pa_prev_q);

  always_comb
  begin
    flags_d = flags_q;
    if (flag_rd)
      flags_d = 4'h0;
    flags_d = flags_d | (act_edge & mask_q);
    if (soft_rst)
      flags_d = 4'h0;
  end

  // flags: a new edge wins over a clearing read
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pa_prev_q              <= 4'h0;
      flags_q                <= 4'h0;
      port_a_summary_request <= 1'b0;
    end
    else
    begin
      pa_prev_q              <= pa_cond;
      flags_q                <= flags_d;
      port_a_summary_request <= |flags_d;
    end
  end

endmodule

`default_nettype wire
